//--- hw/hp_map.svh
// Offsets, field positions, reset values and timing figures of the
// drive protection supervisor. Assumes a 50 MHz clock.
`ifndef HP_MAP_SVH
`define HP_MAP_SVH
`define HP_REG_CTRL 4'h0
`define HP_REG_LEVEL 4'h1
`define HP_REG_RESP 4'h2
`define HP_REG_RED 4'h3
`define HP_REG_PLSET 4'h4
`define HP_REG_FDLY 4'h5
`define HP_REG_AMB 4'h6
`define HP_REG_GAIN 4'h7
`define HP_REG_DOFN 4'h8
`define HP_REG_STAT 4'h9
`define HP_REG_RIPPLE 4'hA
`define HP_CTRL_GF_EN 0
`define HP_CTRL_FAN_MODE 1
`define HP_CTRL_LSO_EN 2
`define HP_CTRL_SCL_EN 3
`define HP_CTRL_HUNT_EN 4
`define HP_CTRL_BRK_SEL 5
`define HP_CTRL_V400 6
`define HP_STAT_OH_FAULT 2
`define HP_STAT_PL_FAULT 3
`define HP_STAT_GF 4
`define HP_RST_CTRL 8'h1D
`define HP_RST_LEVEL 8'h5F
`define HP_MIN_LEVEL 8'h32
`define HP_MAX_LEVEL 8'h82
`define HP_RST_RESP 3'h4
`define HP_MAX_RESP 3'h4
`define HP_RST_RED 10'h0C8
`define HP_MAX_RED 10'h3E8
`define HP_RST_PLSET 8'h32
`define HP_MAX_PLSET 8'hFA
`define HP_RST_FDLY 9'h12C
`define HP_MAX_FDLY 9'h12C
`define HP_MIN_AMB 6'h2D
`define HP_MAX_AMB 6'h3C
`define HP_RST_GAIN 8'h64
`define HP_MAX_GAIN 8'hFA
`define HP_RST_DOFN 8'h00
`define HP_DO_OH_PRE 8'h14
`define HP_RED_SCALE 1000
`define HP_GAIN_SCALE 100
`define HP_SCANS 4'h9
`define HP_LS_FREQ 16'h0258
`define HP_CLK_KHZ 50000
`define HP_PL_START_MS 12000
`define HP_PL_SCAN_MS 1280
`define HP_SEC_MS 1000
`endif

//--- hw/hp_pkg.sv
// Types of the drive protection supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package hp_pkg;
  typedef enum logic [1:0] {
    HP_PL_WAIT = 2'b01,
    HP_PL_SCAN = 2'b10
  } hp_pl_e;
  typedef enum logic [1:0] {
    HP_STOP_NONE = 2'b00,
    HP_STOP_RAMP = 2'b01,
    HP_STOP_COAST = 2'b10,
    HP_STOP_FAST = 2'b11
  } hp_stop_e;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] level;
    logic [2:0] resp;
    logic [9:0] red;
    logic [7:0] plset;
    logic [8:0] fdly;
    logic [5:0] amb;
    logic [7:0] gain;
    logic [7:0] dofn;
    logic oh_raw;
    logic oh_alarm;
    logic oh_fault;
    logic dout;
    hp_stop_e stop;
    logic pl_fault;
    logic gf;
    logic fan;
    logic [8:0] fan_s;
    logic [31:0] tick;
    hp_pl_e pl;
    logic [31:0] pl_cnt;
    logic [9:0] vmin;
    logic [9:0] vmax;
    logic [13:0] sum;
    logic [13:0] ripple;
    logic [3:0] nscan;
    logic [15:0] spd;
    logic cl;
    logic ol_fast;
    logic [7:0] ol_pct;
    logic [15:0] vadj;
    logic [15:0] rdata;
    logic run_s1;
    logic run_s2;
  } hp_state_s;
endpackage : hp_pkg

//--- hw/hp_protect.sv
// Drive protection supervisor: overheat, phase loss, ground fault, fan,
// overload derating, soft current limit and hunting prevention.
// Assumes sensor values come from logic on clk; run_cmd is a pin.
//
// The register offsets and the plain strobed port were left to the implementer.
`include "hp_map.svh"
module hp_protect
  import hp_pkg::*;
#(
  parameter int NUM_SENS = 3,
  parameter logic [15:0] RATED_I = 16'h03E8,
  parameter logic [15:0] CL_STEP = 16'h0001,
  parameter int unsigned START_CYC = `HP_CLK_KHZ * `HP_PL_START_MS,
  parameter int unsigned SCAN_CYC = `HP_CLK_KHZ * `HP_PL_SCAN_MS,
  parameter int unsigned SEC_CYC = `HP_CLK_KHZ * `HP_SEC_MS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [NUM_SENS*8-1:0] sink_temp,
  input wire logic [9:0] bus_volt,
  input wire logic bus_valid,
  input wire logic signed [15:0] phase_a,
  input wire logic signed [15:0] phase_b,
  input wire logic signed [15:0] phase_c,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_cur,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] max_freq,
  input wire logic signed [15:0] mag_err,
  input wire logic run_cmd,
  output logic overheat_alarm,
  output logic overheat_prealarm_fault,
  output logic [1:0] stop_mode,
  output logic dout_close,
  output logic input_phase_loss_fault,
  output logic ground_fault,
  output logic fan_on,
  output logic [15:0] speed_out,
  output logic current_limit_active,
  output logic ol_fast,
  output logic [7:0] ol_level_pct,
  output logic [15:0] volt_adj
);
  localparam logic [7:0] DERATE [0:15] = '{
    8'h64, 8'h62, 8'h60, 8'h5E, 8'h5C, 8'h5A, 8'h58, 8'h56,
    8'h54, 8'h52, 8'h50, 8'h4E, 8'h4C, 8'h4A, 8'h48, 8'h46
  };
  localparam hp_state_s RST = '{
    ctrl: `HP_RST_CTRL, level: `HP_RST_LEVEL, resp: `HP_RST_RESP,
    red: `HP_RST_RED, plset: `HP_RST_PLSET, fdly: `HP_RST_FDLY,
    amb: `HP_MIN_AMB, gain: `HP_RST_GAIN, dofn: `HP_RST_DOFN,
    stop: HP_STOP_NONE, pl: HP_PL_WAIT, vmin: 10'h3FF, ol_pct: 8'h64,
    default: '0
  };

  hp_state_s st;
  hp_state_s next_st;
  logic [NUM_SENS-1:0] hot;
  logic hot_any;
  logic [9:0] diff;
  logic [13:0] sum_new;
  logic [13:0] trip;
  logic signed [17:0] gnd;
  logic [17:0] gnd_abs;
  logic [25:0] red_prod;
  logic [15:0] red_amt;
  logic [15:0] spd_base;
  logic [15:0] spd_cl;
  logic signed [24:0] hunt_prod;
  logic scan_end;
  logic cl_now;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // Per-sensor pre-alarm compare
  for (genvar i = 0; i < NUM_SENS; i++) begin : g_sens
    assign hot[i] = sink_temp[i*8 +: 8] > st.level;
  end
  assign hot_any = |hot;

  always_comb begin
    next_st = st;
    diff = (st.vmax > st.vmin) ? st.vmax - st.vmin : 10'h000;
    sum_new = st.sum + {4'h0, diff};
    trip = st.ctrl[`HP_CTRL_V400] ? {4'h0, st.plset, 2'b00} << 1
                                  : {4'h0, st.plset, 2'b00};
    gnd = 18'(phase_a) + 18'(phase_b) + 18'(phase_c);
    gnd_abs = gnd[17] ? 18'(-gnd) : 18'(gnd);
    red_prod = max_freq * st.red;
    red_amt = 16'(red_prod / `HP_RED_SCALE);
    hunt_prod = mag_err * $signed({1'b0, st.gain});
    scan_end = st.pl_cnt == SCAN_CYC - 1;
    cl_now = st.ctrl[`HP_CTRL_SCL_EN] &&
             (20'(out_cur) * 20'd10 > 20'(RATED_I) * 20'd11);
    spd_base = speed_cmd;
    spd_cl = (out_freq > CL_STEP) ? out_freq - CL_STEP : 16'h0000;

    // Pin synchroniser
    next_st.run_s1 = run_cmd;
    next_st.run_s2 = st.run_s1;

    // Register writes; out-of-range values are clamped, except CTRL and DOFN, which take the low byte of wdata
    if (wr) begin
      case (addr)
        `HP_REG_CTRL: next_st.ctrl = wdata[7:0];
        `HP_REG_LEVEL: next_st.level = 8'(clamp(wdata,
          16'(`HP_MIN_LEVEL), 16'(`HP_MAX_LEVEL)));
        `HP_REG_RESP: next_st.resp = 3'(clamp(wdata, 16'h0000,
          16'(`HP_MAX_RESP)));
        `HP_REG_RED: next_st.red = 10'(clamp(wdata, 16'h0000,
          16'(`HP_MAX_RED)));
        `HP_REG_PLSET: next_st.plset = 8'(clamp(wdata, 16'h0000,
          16'(`HP_MAX_PLSET)));
        `HP_REG_FDLY: next_st.fdly = 9'(clamp(wdata, 16'h0000,
          16'(`HP_MAX_FDLY)));
        `HP_REG_AMB: next_st.amb = 6'(clamp(wdata, 16'(`HP_MIN_AMB),
          16'(`HP_MAX_AMB)));
        `HP_REG_GAIN: next_st.gain = 8'(clamp(wdata, 16'h0000,
          16'(`HP_MAX_GAIN)));
        `HP_REG_DOFN: next_st.dofn = wdata[7:0];
        `HP_REG_STAT: begin
          if (wdata[`HP_STAT_OH_FAULT]) next_st.oh_fault = 1'b0;
          if (wdata[`HP_STAT_PL_FAULT]) next_st.pl_fault = 1'b0;
          if (wdata[`HP_STAT_GF]) next_st.gf = 1'b0;
        end
        default: ;
      endcase
    end

    // Overheat detection and response; a set beats a clear
    next_st.oh_raw = hot_any;
    next_st.dout = st.oh_raw && (st.dofn == `HP_DO_OH_PRE);
    next_st.oh_alarm = st.oh_raw && (st.resp >= 3'h3);
    if (st.oh_raw && st.resp < 3'h3) next_st.oh_fault = 1'b1;

    // Ground fault
    if (st.ctrl[`HP_CTRL_GF_EN] && (gnd_abs << 1) > 18'(RATED_I))
      next_st.gf = 1'b1;

    // Phase loss scanner
    case (st.pl)
      HP_PL_WAIT: begin
        next_st.pl_cnt = st.pl_cnt + 32'h0000_0001;
        if (st.pl_cnt == START_CYC - 1) begin
          next_st.pl = HP_PL_SCAN;
          next_st.pl_cnt = '0;
        end
      end
      HP_PL_SCAN: begin
        next_st.pl_cnt = st.pl_cnt + 32'h0000_0001;
        if (bus_valid && bus_volt < st.vmin) next_st.vmin = bus_volt;
        if (bus_valid && bus_volt > st.vmax) next_st.vmax = bus_volt;
        if (scan_end) begin
          next_st.pl_cnt = '0;
          next_st.vmin = 10'h3FF;
          next_st.vmax = 10'h000;
          next_st.sum = sum_new;
          next_st.nscan = st.nscan + 4'h1;
          if (st.nscan == `HP_SCANS) begin
            next_st.nscan = 4'h0;
            next_st.sum = 14'h0000;
            next_st.ripple = sum_new;
            if (sum_new > trip) next_st.pl_fault = 1'b1;
          end
        end
      end
      default: begin
        next_st.pl = HP_PL_WAIT;
        next_st.pl_cnt = '0;
      end
    endcase

    // Stop request; coast wins over the other stops
    if (st.gf || st.pl_fault) next_st.stop = HP_STOP_COAST;
    else if (st.oh_fault) begin
      case (st.resp)
        3'h0: next_st.stop = HP_STOP_RAMP;
        3'h1: next_st.stop = HP_STOP_COAST;
        3'h2: next_st.stop = HP_STOP_FAST;
        default: next_st.stop = HP_STOP_NONE;
      endcase
    end else next_st.stop = HP_STOP_NONE;

    // Speed reduction and soft current limit
    if (st.oh_raw && st.resp == `HP_MAX_RESP)
      spd_base = (speed_cmd > red_amt) ? speed_cmd - red_amt
                                       : 16'h0000;
    next_st.cl = cl_now;
    next_st.spd = (cl_now && spd_cl < spd_base) ? spd_cl : spd_base;

    // Overload shaping
    next_st.ol_fast = st.ctrl[`HP_CTRL_LSO_EN] && out_freq <= `HP_LS_FREQ
                      && out_cur > RATED_I;
    next_st.ol_pct = DERATE[4'(st.amb - `HP_MIN_AMB)];

    // Hunting prevention voltage trim
    next_st.vadj = st.ctrl[`HP_CTRL_HUNT_EN]
                   ? 16'(-(hunt_prod / 25'sd100)) : 16'h0000;

    // Fan control with delayed turn-off
    next_st.tick = (st.tick == SEC_CYC - 1) ? '0 : st.tick + 32'h0000_0001;
    if (st.ctrl[`HP_CTRL_FAN_MODE]) begin
      next_st.fan = 1'b1;
      next_st.fan_s = 9'h000;
    end else if (st.run_s2) begin
      next_st.fan = 1'b1;
      next_st.fan_s = st.fdly;
    end else begin
      if (st.fan_s != 9'h000 && st.tick == SEC_CYC - 1)
        next_st.fan_s = st.fan_s - 9'h001;
      next_st.fan = next_st.fan_s != 9'h000;
    end

    // Register reads, data in the following cycle
    next_st.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `HP_REG_CTRL: next_st.rdata = {8'h00, st.ctrl};
        `HP_REG_LEVEL: next_st.rdata = {8'h00, st.level};
        `HP_REG_RESP: next_st.rdata = {13'h0000, st.resp};
        `HP_REG_RED: next_st.rdata = {6'h00, st.red};
        `HP_REG_PLSET: next_st.rdata = {8'h00, st.plset};
        `HP_REG_FDLY: next_st.rdata = {7'h00, st.fdly};
        `HP_REG_AMB: next_st.rdata = {10'h000, st.amb};
        `HP_REG_GAIN: next_st.rdata = {8'h00, st.gain};
        `HP_REG_DOFN: next_st.rdata = {8'h00, st.dofn};
        `HP_REG_STAT: next_st.rdata = {6'h00, st.stop, st.ol_fast, st.cl,
          st.fan, st.gf, st.pl_fault, st.oh_fault, st.oh_alarm, st.oh_raw};
        `HP_REG_RIPPLE: next_st.rdata = {2'h0, st.ripple};
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st <= RST;
    else st <= next_st;
  end

  assign rdata = st.rdata;
  assign overheat_alarm = st.oh_alarm;
  assign overheat_prealarm_fault = st.oh_fault;
  assign stop_mode = st.stop;
  assign dout_close = st.dout;
  assign input_phase_loss_fault = st.pl_fault;
  assign ground_fault = st.gf;
  assign fan_on = st.fan;
  assign speed_out = st.spd;
  assign current_limit_active = st.cl;
  assign ol_fast = st.ol_fast;
  assign ol_level_pct = st.ol_pct;
  assign volt_adj = st.vadj;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_hot_sets_raw: assert property (hot_any |=> st.oh_raw)
    else $error("overheat not flagged");
  a_level_range: assert property (st.level >= `HP_MIN_LEVEL &&
    st.level <= `HP_MAX_LEVEL)
    else $error("pre-alarm level out of range");
  a_resp_coast_stop: assert property (st.oh_fault && st.resp == 3'h1
    |=> stop_mode == HP_STOP_COAST)
    else $error("coast response not applied");
  a_reduce_speed: assert property (st.oh_raw && st.resp == 3'h4
    && st.red != 10'h000 && max_freq >= 16'h03E8 && speed_cmd != 16'h0000
    |=> speed_out < $past(speed_cmd))
    else $error("speed not reduced");
  a_dout_prealarm: assert property (st.oh_raw && st.dofn == `HP_DO_OH_PRE
    |=> dout_close)
    else $error("pre-alarm output not closed");
  a_pl_wait_start: assert property (st.pl == HP_PL_WAIT
    |-> st.nscan == 4'h0 && !input_phase_loss_fault)
    else $error("phase loss scanned during start delay");
  a_pl_fault_stop: assert property (input_phase_loss_fault
    |=> stop_mode == HP_STOP_COAST)
    else $error("phase loss did not stop");
  a_gf_coast: assert property (ground_fault
    |=> stop_mode == HP_STOP_COAST)
    else $error("ground fault did not coast");
  a_fan_always: assert property (st.ctrl[`HP_CTRL_FAN_MODE]
    |=> fan_on)
    else $error("fan off in always-on mode");
  a_fan_run: assert property (st.run_s2 |=> fan_on)
    else $error("fan off while running");
  a_cl_disabled: assert property (!st.ctrl[`HP_CTRL_SCL_EN]
    |=> !current_limit_active)
    else $error("current limit while disabled");
  a_derate_nominal: assert property (st.amb == `HP_MIN_AMB
    |=> ol_level_pct == 8'h64)
    else $error("derating at nominal ambient");
  a_hunt_off: assert property (!st.ctrl[`HP_CTRL_HUNT_EN]
    |=> volt_adj == 16'h0000)
    else $error("voltage trim while disabled");
  a_read_level: assert property (rd && addr == `HP_REG_LEVEL
    |=> rdata == {8'h00, $past(st.level)})
    else $error("read data wrong");

  a_resp_ramp_stop: assert property (!st.gf && !st.pl_fault && st.oh_fault
    && st.resp == 3'h0 |=> stop_mode == HP_STOP_RAMP)
    else $error("ramp response not applied");

  a_resp_fast_stop: assert property (!st.gf && !st.pl_fault && st.oh_fault
    && st.resp == 3'h2 |=> stop_mode == HP_STOP_FAST)
    else $error("fast stop response not applied");

  a_no_fault_run: assert property (!st.gf && !st.pl_fault && !st.oh_fault
    |=> stop_mode == HP_STOP_NONE)
    else $error("stop without a fault");

  a_alarm_only: assert property (st.oh_raw && st.resp >= 3'h3
    |=> overheat_alarm)
    else $error("alarm response not given");

  a_fault_sets: assert property (st.oh_raw && st.resp < 3'h3
    |=> overheat_prealarm_fault)
    else $error("overheat fault not set");

  a_gf_sets: assert property (st.ctrl[`HP_CTRL_GF_EN]
    && gnd_abs > 18'(RATED_I >> 1) |=> ground_fault)
    else $error("ground fault not flagged");

  a_gf_disabled: assert property (!st.ctrl[`HP_CTRL_GF_EN] && !ground_fault
    |=> !ground_fault)
    else $error("ground fault while disabled");

  a_cl_sets: assert property (st.ctrl[`HP_CTRL_SCL_EN]
    && 20'(out_cur) * 20'd10 > 20'(RATED_I) * 20'd11
    |=> current_limit_active)
    else $error("current limit not active");

  a_cl_speed: assert property (current_limit_active && $past(out_freq) != 0
    |-> speed_out < $past(out_freq))
    else $error("speed not limited");

  a_olf_disabled: assert property (!st.ctrl[`HP_CTRL_LSO_EN]
    |=> !ol_fast)
    else $error("fast overload while disabled");

  a_olf_high_freq: assert property (out_freq > `HP_LS_FREQ
    |=> !ol_fast)
    else $error("fast overload above low speed");

  a_derate_above: assert property (st.amb > `HP_MIN_AMB
    |=> ol_level_pct < 8'h64)
    else $error("overload level not derated");

  a_fan_stays_off: assert property (!st.ctrl[`HP_CTRL_FAN_MODE]
    && !st.run_s2 && st.fan_s == 9'h000 |=> !fan_on)
    else $error("fan on after delay ran out");

  a_dout_other_fn: assert property (st.dofn != `HP_DO_OH_PRE
    |=> !dout_close)
    else $error("output closed for other function");

  a_gain_range: assert property (st.gain <= `HP_MAX_GAIN)
    else $error("hunting gain out of range");

  a_red_range: assert property (st.red <= `HP_MAX_RED)
    else $error("reduction out of range");

  a_resp_range: assert property (st.resp <= `HP_MAX_RESP)
    else $error("response code out of range");

  c_ground_fault: cover property ($rose(ground_fault));
  c_phase_loss: cover property ($rose(input_phase_loss_fault));
  c_fan_delay_off: cover property ($fell(fan_on));
  c_oh_reduce: cover property (overheat_alarm && st.resp == 3'h4);
  c_cur_limit: cover property ($rose(current_limit_active));
endmodule : hp_protect

//--- testbench/hp_plant.sv
// Sensor model: heatsink thermistors, DC bus with ripple, phase currents.
// Assumes the bench sets hot sensor, ripple depth and ground leak.
module hp_plant #(
  parameter int NS = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] hot_idx,
  input wire logic [7:0] hot_temp,
  input wire logic [9:0] ripple,
  input wire logic signed [15:0] leak,
  output logic [NS*8-1:0] sink_temp,
  output logic [9:0] bus_volt,
  output logic bus_valid,
  output logic signed [15:0] phase_a,
  output logic signed [15:0] phase_b,
  output logic signed [15:0] phase_c
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] x;
  logic tog;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      x <= 10'h000;
      tog <= 1'b0;
    end else begin
      x <= x + 10'h007;
      tog <= ~tog;
    end
  end
  always_comb begin
    for (int k = 0; k < NS; k++) begin
      sink_temp[8*k+:8] = (k == int'(hot_idx)) ? hot_temp : 8'h28;
    end
  end
  // Ripple swings between two levels on alternate samples
  assign bus_volt = tog ? 10'h1F4 + ripple : 10'h1F4;
  assign bus_valid = nrst;
  // Load current moves every cycle; only the leak reaches ground
  assign phase_a = signed'({6'h00, x}) + leak;
  assign phase_b = -signed'({6'h00, x});
  assign phase_c = 16'sh0000;
endmodule : hp_plant

//--- testbench/tb_top.sv
// Self-checking bench of the drive protection supervisor.
// Assumes shortened phase loss and second timings at the instance.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, wr, rd, run_cmd, rd_seen, bus_valid;
  logic [3:0] addr;
  logic [15:0] wdata, out_freq, out_cur, speed_cmd, max_freq, sp;
  logic signed [15:0] mag_err, leak, phase_a, phase_b, phase_c;
  logic [23:0] sink_temp;
  logic [9:0] bus_volt, ripple;
  logic [1:0] hot_idx, stop_mode;
  logic [7:0] hot_temp, ol_level_pct;
  logic overheat_alarm, overheat_prealarm_fault, dout_close, ol_fast;
  logic input_phase_loss_fault, ground_fault, fan_on, current_limit_active;
  logic [15:0] rdata, speed_out, volt_adj;
  logic [15:0] rq[$];
  logic [19:0] rv[10];
  logic [15:0] am[5];
  int n_mismatch, n_compared, seed, i;

  hp_protect #(.START_CYC(40), .SCAN_CYC(20), .SEC_CYC(10)) i_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sink_temp(sink_temp), .bus_volt(bus_volt),
    .bus_valid(bus_valid), .phase_a(phase_a), .phase_b(phase_b),
    .phase_c(phase_c), .out_freq(out_freq), .out_cur(out_cur),
    .speed_cmd(speed_cmd), .max_freq(max_freq), .mag_err(mag_err),
    .run_cmd(run_cmd), .overheat_alarm(overheat_alarm),
    .overheat_prealarm_fault(overheat_prealarm_fault),
    .stop_mode(stop_mode), .dout_close(dout_close),
    .input_phase_loss_fault(input_phase_loss_fault),
    .ground_fault(ground_fault), .fan_on(fan_on), .speed_out(speed_out),
    .current_limit_active(current_limit_active), .ol_fast(ol_fast),
    .ol_level_pct(ol_level_pct), .volt_adj(volt_adj)
  );
  hp_plant #(.NS(3)) i_plant (
    .clk(clk), .nrst(nrst), .hot_idx(hot_idx), .hot_temp(hot_temp),
    .ripple(ripple), .leak(leak), .sink_temp(sink_temp),
    .bus_volt(bus_volt), .bus_valid(bus_valid), .phase_a(phase_a),
    .phase_b(phase_b), .phase_c(phase_c)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Read data stand in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen === 1'b1 && rq.size() > 0) begin
      chk("rdata", rdata, rq.pop_front());
    end
    rd_seen <= rd;
  end

  initial begin
    cyc(20000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    seed = 66120;
    nrst = 1'b0;
    {wr, rd, rd_seen, run_cmd} = 4'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    out_freq = 16'h0BB8;
    out_cur = 16'h01F4;
    speed_cmd = 16'h0BB8;
    sp = 16'h0BB8;
    max_freq = 16'h1770;
    mag_err = 16'sh0000;
    leak = 16'sh0000;
    ripple = 10'h014;
    hot_idx = 2'h0;
    hot_temp = 8'h28;
    rv = '{20'h0_001D, 20'h1_005F, 20'h2_0004, 20'h3_00C8, 20'h4_0032,
      20'h5_012C, 20'h6_002D, 20'h7_0064, 20'h8_0000, 20'hB_0000};
    am = '{16'h3C46, 16'h325A, 16'h2E62, 16'h2D64, 16'h4646};
    cyc(4);
    nrst <= 1'b1;
    cyc(3);
    chk("fan", 16'(fan_on), 16'h0000);
    foreach (rv[k]) rreg(rv[k][19:16], rv[k][15:0]);
    wreg(4'h1, 16'h00C8);
    rreg(4'h1, 16'h0082);
    wreg(4'h1, 16'h000A);
    rreg(4'h1, 16'h0032);
    wreg(4'h1, 16'h005F);
    sp = 16'h0BB8 + 16'($random(seed) & 32'h3FF);
    speed_cmd <= sp;
    hot_idx <= 2'h1;
    hot_temp <= 8'h60;
    cyc(4);
    chk("alarm", 16'(overheat_alarm), 16'h0001);
    chk("dout", 16'(dout_close), 16'h0000);
    chk("speed", speed_out, sp - 16'h04B0);
    hot_temp <= 8'h5F;
    cyc(4);
    chk("alarm", 16'(overheat_alarm), 16'h0000);
    chk("speed", speed_out, sp);
    wreg(4'h8, 16'h0014);
    for (i = 0; i < 5; i++) begin
      wreg(4'h2, 16'(i));
      hot_idx <= 2'(i % 3);
      hot_temp <= 8'h60 + 8'($random(seed) & 32'h3F);
      cyc(4);
      chk("stop", 16'(stop_mode), (i < 3) ? 16'(i + 1) : 16'h0000);
      chk("fault", 16'(overheat_prealarm_fault), 16'(i < 3));
      chk("alarm", 16'(overheat_alarm), 16'(i > 2));
      chk("dout", 16'(dout_close), 16'h0001);
      hot_temp <= 8'h28;
      wreg(4'h9, 16'h001C);
      cyc(4);
      chk("stop", 16'(stop_mode), 16'h0000);
    end
    leak <= 16'sd500;
    cyc(4);
    chk("gf", 16'(ground_fault), 16'h0000);
    leak <= -16'sd501;
    cyc(4);
    chk("gf", 16'(ground_fault), 16'h0001);
    chk("stop", 16'(stop_mode), 16'h0002);
    leak <= 16'sd0;
    wreg(4'h9, 16'h001C);
    wreg(4'h0, 16'h001C);
    leak <= 16'sd600;
    cyc(4);
    chk("gf", 16'(ground_fault), 16'h0000);
    leak <= 16'sd0;
    wreg(4'h0, 16'h001D);
    out_cur <= 16'd1100;
    cyc(3);
    chk("cl", 16'(current_limit_active), 16'h0000);
    out_cur <= 16'd1101;
    cyc(3);
    chk("cl", 16'(current_limit_active), 16'h0001);
    chk("speed", speed_out, 16'h0BB7);
    wreg(4'h0, 16'h0015);
    cyc(3);
    chk("cl", 16'(current_limit_active), 16'h0000);
    chk("speed", speed_out, sp);
    wreg(4'h0, 16'h001D);
    out_freq <= 16'h0258;
    cyc(3);
    chk("olf", 16'(ol_fast), 16'h0001);
    out_freq <= 16'h0259;
    cyc(3);
    chk("olf", 16'(ol_fast), 16'h0000);
    out_freq <= 16'h0258;
    wreg(4'h0, 16'h0019);
    cyc(3);
    chk("olf", 16'(ol_fast), 16'h0000);
    wreg(4'h0, 16'h001D);
    out_cur <= 16'h01F4;
    out_freq <= 16'h0BB8;
    foreach (am[k]) begin
      wreg(4'h6, 16'(am[k][15:8]));
      cyc(3);
      chk("olpct", 16'(ol_level_pct), 16'(am[k][7:0]));
    end
    mag_err <= 16'sd50;
    cyc(3);
    chk("vadj", volt_adj, 16'hFFCE);
    wreg(4'h7, 16'h00FA);
    cyc(3);
    chk("vadj", volt_adj, 16'hFF83);
    wreg(4'h0, 16'h000D);
    cyc(3);
    chk("vadj", volt_adj, 16'h0000);
    wreg(4'h0, 16'h003D);
    rreg(4'h0, 16'h003D);
    cyc(3);
    chk("speed", speed_out, sp);
    wreg(4'h0, 16'h001D);
    wreg(4'h5, 16'h0003);
    run_cmd <= 1'b1;
    cyc(5);
    chk("fan", 16'(fan_on), 16'h0001);
    run_cmd <= 1'b0;
    cyc(15);
    chk("fan", 16'(fan_on), 16'h0001);
    cyc(25);
    chk("fan", 16'(fan_on), 16'h0000);
    wreg(4'h0, 16'h001F);
    cyc(3);
    chk("fan", 16'(fan_on), 16'h0001);
    wreg(4'h0, 16'h001D);
    rreg(4'hA, 16'h00C8);
    chk("pl", 16'(input_phase_loss_fault), 16'h0000);
    ripple <= 10'd21;
    cyc(500);
    chk("pl", 16'(input_phase_loss_fault), 16'h0001);
    wreg(4'h0, 16'h005D);
    wreg(4'h9, 16'h001C);
    cyc(500);
    chk("pl", 16'(input_phase_loss_fault), 16'h0000);
    ripple <= 10'd41;
    cyc(500);
    chk("pl", 16'(input_phase_loss_fault), 16'h0001);
    cyc(4);
    tally_and_finish();
  end
endmodule : tb_top
